// ---- pmsr_pkg.sv ----
// Purpose: Constants and carriers for the transceiver misc status register bank
// Assumes: AXI4-Lite, 32-bit data, 16-bit registers in the low half of each word
// Notes:   Printed offsets are not all multiples of four, so they are indices (byte = 4 x index)
package pmsr_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte address width
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_FAST_RX    = 8'h43;
  localparam logic [7:0]  IDX_SYNC       = 8'h4F;
  localparam logic [7:0]  IDX_SFD_VAR    = 8'h55;
  localparam logic [7:0]  IDX_STRAPS     = 8'h6E;
  localparam logic [7:0]  IDX_TOTAL      = 8'h71;
  localparam logic [7:0]  IDX_ERRCNT     = 8'h72;
  localparam logic [7:0]  IDX_CHK_CTRL   = 8'h16;
  localparam logic [7:0]  IDX_IRQ_STAT   = 8'hF0;
  localparam logic [7:0]  IDX_IRQ_MASK   = 8'hF1;
  localparam int          ADDR_W         = 10;

  // ----------------------------------------------------------------
  // Reset values and field layouts
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_FAST_RX    = 16'h07A0;
  localparam logic [15:0] FAST_RX_RW_MSK = 16'h0FFF;
  localparam logic [15:0] SYNC_RW_MSK    = 16'hF800;
  localparam int          SYNC_BIT       = 8;
  localparam int          LLF_BIT        = 13;
  localparam int          MIRROR_BIT     = 12;
  localparam int          OPMODE_LSB     = 9;
  localparam int          PORTADDR_LSB   = 4;
  localparam int          ANSEL_LSB      = 2;
  localparam int          ANEN_BIT       = 1;
  localparam int          FREEZE_BIT     = 0;
  localparam int          FREEZE_CLR_BIT = 1;
  localparam int          ERR_OVF_BIT    = 9;
  localparam int          CHK_EN_BIT     = 0;
  localparam int          CHK_MODE_BIT   = 1;
  localparam logic [15:0] TOTAL_MAX      = 16'hFFFF;
  localparam logic [7:0]  ERR_MAX        = 8'hFF;
  localparam int          NIRQ           = 3;
  localparam int          IRQ_SYNC_UP    = 0;
  localparam int          IRQ_SYNC_DN    = 1;
  localparam int          IRQ_TOTAL_SAT  = 2;

  // ----------------------------------------------------------------
  // Operating mode strap codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PMSR_RGMII_COPPER = 3'h0,
    PMSR_RGMII_1000X  = 3'h1,
    PMSR_RGMII_100FX  = 3'h2,
    PMSR_RGMII_SGMII  = 3'h3,
    PMSR_1000T_1000X  = 3'h4,
    PMSR_100T_100FX   = 3'h5,
    PMSR_SGMII_COPPER = 3'h6,
    PMSR_JTAG_SCAN    = 3'h7
  } pmsr_opmode_e;

  // Strap snapshot as sampled after reset release
  typedef struct packed {
    logic         link_loss_forward;
    logic         mirror;
    pmsr_opmode_e opmode;
    logic [4:0]   port_address;
    logic [1:0]   autoneg_mode_select;
    logic         autoneg_enable;
  } pmsr_strap_s;

  // Checker byte stream from the pattern checker
  typedef struct packed {
    logic byte_valid;
    logic byte_error;
  } pmsr_chk_s;

endpackage : pmsr_pkg

// ---- pmsr_regs.sv ----
// Purpose: Miscellaneous transceiver status/control register bank on AXI4-Lite
// Assumes: Single clock aclk 125 MHz; straps and sync status come from pins
// Notes:   All outputs registered; SLVERR on unmapped addresses
//
// Function
// - Bit 0 of the fast receive-valid control, when 1, drives early receive-valid for 100 Mbps.
// - Bit 8 of the sync state register reads 1 when serial sync is established, else 0.
// - Bits 7-4 of the variation status show the gigabit master-mode delimiter variation.
// - Bits 3-0 of the variation status show the gigabit slave-mode delimiter variation.
// - Strap bit 13 reads the latched link-loss forwarding strap, 0 enabled, 1 disabled.
// - Strap bit 12 reads the latched mirror strap, 0 disabled, 1 enabled.
// - In bridge modes the latched mirror strap also selects the MAC interface type.
// - Strap bits 11-9 hold the latched operating mode with its eight codes.
// - Strap bits 3-2 hold the latched auto-negotiation mode select.
// - Strap bit 1 holds the latched auto-negotiation enable, 0 enabled, 1 disabled.
// - A read-only 16-bit count of checker total bytes is kept.
// - Writing bit 0 or bit 1 of the error-count register freezes the visible total.
// - In single count mode the total-byte counter stops at 0xFFFF.
// - Writing bit 1 of the error-count register also clears counters and overflow flags.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module pmsr_regs (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [9:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [9:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire pmsr_pkg::pmsr_strap_s strap_pins,
  input  wire logic                 serial_sync_pin,
  input  wire logic [3:0]           master_delimiter_variation,
  input  wire logic [3:0]           slave_delimiter_variation,
  input  wire pmsr_pkg::pmsr_chk_s  checker_in,
  output logic                      early_receive_valid_en,
  output logic                      mac_if_select,
  output logic                      irq
);
  import pmsr_pkg::*;

  // ----------------------------------------------------------------
  // Register map (word index, byte address is four times it)
  // ----------------------------------------------------------------
  // 0x43 fast receive-valid control
  //   15:12 read as zero, writes dropped
  //   11:1  stored, no effect on behaviour
  //   0     early receive-valid enable
  // 0x4F serial link sync state
  //   15:11 stored, no effect on behaviour
  //   8     synchronised pin level
  //   rest  read as zero
  // 0x55 delimiter variation, live pins
  //   7:4   master-mode variation
  //   3:0   slave-mode variation
  // 0x6E strap snapshot
  //   13    link-loss forwarding strap
  //   12    mirror strap
  //   11:9  operating mode code
  //   8:4   port address strap
  //   3:2   auto-negotiation mode select
  //   1     auto-negotiation enable
  // 0x71 checker total bytes, frozen view
  // 0x72 checker errored bytes
  //   write bit 0 freezes the views
  //   write bit 1 freezes and clears
  //   read bit 9 byte counter overflow
  //   read 7:0 errored byte view
  // 0x16 checker control
  //   bit 0 enable, bit 1 wrap mode
  // 0xF0 interrupt status, read clears
  // 0xF1 interrupt mask
  // Any other index answers SLVERR

  // ----------------------------------------------------------------
  // Bus timing
  // ----------------------------------------------------------------
  // Write address and data are taken in either
  // order; each ready drops once its channel is
  // taken and rises again after the response is
  // accepted, so one write is in flight at most.
  // The response comes two cycles after the later
  // of the two takes and stands until bready.
  // A read is answered one cycle after it is
  // taken; data stand until rready is seen.
  // Reads and writes run independently.
  // Only byte lanes 0 and 1 reach the registers;
  // an unset strobe writes zeros to its lane.

  // ----------------------------------------------------------------
  // Counters and events
  // ----------------------------------------------------------------
  // The live total counts every valid checker
  // byte while enabled. In saturating mode it
  // parks at all ones and raises one event; in
  // wrap mode it rolls over and sets overflow.
  // The visible views follow the live counts
  // until the first freeze write; each freeze
  // write loads a snapshot that holds until the
  // next one or reset, so software sees a stable pair.
  // Trade-off: freeze is sticky; a fresh reset
  // is the only way to resume tracking.
  // Interrupt status bits are sticky; a read of
  // the status clears them, but an event in the
  // same cycle wins so nothing is lost.
  // irq is the OR of masked status bits.

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  // Straps are caught once, in the first cycle
  // after reset release; they must be steady
  // then. Later strap changes are not seen.
  // The sync pin passes three flops; a new
  // level counts once stages two and three
  // agree, which filters one-cycle glitches.
  // The delimiter variation pins are read
  // straight into the read data; they are
  // expected to be quasi-static.
  // The interface select follows the latched
  // mirror strap in the two bridge modes only.

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              aw_have;
    logic              w_have;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [15:0]       fast_rx;
    logic [15:0]       sync_rw;
    logic [2:0]        sync_sh;
    logic              sync_st;
    logic              straps_taken;
    pmsr_strap_s       straps;
    logic [1:0]        chk_ctrl;
    logic [15:0]       total_live;
    logic [15:0]       total_view;
    logic              frozen;
    logic              total_ovf;
    logic [7:0]        err_live;
    logic [7:0]        err_view;
    logic [NIRQ-1:0]   irq_stat;
    logic [NIRQ-1:0]   irq_mask;
    logic              erv;
    logic              macsel;
    logic              irq;
  } pmsr_state_s;

  pmsr_state_s st_reg;
  pmsr_state_s st_next;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // One combinational block; bus, straps, counters and interrupts share it
  always_comb begin
    logic            wr_fire;
    logic            rd_fire;
    logic [7:0]      widx;
    logic [7:0]      ridx;
    logic [15:0]     wd;
    logic [15:0]     rd;
    logic            rd_ok;
    logic            wr_ok;
    logic [NIRQ-1:0] ev;
    logic            do_freeze;
    logic            do_clear;
    logic            sync_rise;
    logic            sync_fall;
    st_next   = st_reg;
    wr_fire   = 1'b0;
    rd_fire   = 1'b0;
    widx      = st_reg.aw_addr[ADDR_W-1:2];
    ridx      = s_axi_araddr[ADDR_W-1:2];
    wd        = 16'h0000;
    rd        = 16'h0000;
    rd_ok     = 1'b1;
    wr_ok     = 1'b1;
    ev        = '0;
    do_freeze = 1'b0;
    do_clear  = 1'b0;
    sync_rise = 1'b0;
    sync_fall = 1'b0;

    // Write channels taken in either order, response after both
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_have = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
      st_next.awready = 1'b0;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_have = 1'b1;
      st_next.wdata  = s_axi_wdata;
      st_next.wstrb  = s_axi_wstrb;
      st_next.wready = 1'b0;
    end
    if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
      wr_fire         = 1'b1;
      st_next.aw_have = 1'b0;
      st_next.w_have  = 1'b0;
      st_next.bvalid  = 1'b1;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid  = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready  = 1'b1;
    end

    // Only the low two byte lanes carry register bits; others are dropped
    wd = {st_reg.wstrb[1] ? st_reg.wdata[15:8] : 8'h00, st_reg.wstrb[0] ? st_reg.wdata[7:0] : 8'h00};

    // Pin synchroniser; a change counts once stages two and three agree
    st_next.sync_sh = {st_reg.sync_sh[1:0], serial_sync_pin};
    if (st_reg.sync_sh[1] == st_reg.sync_sh[2]) begin
      st_next.sync_st = st_reg.sync_sh[2];
      sync_rise       = st_reg.sync_sh[2] && !st_reg.sync_st;
      sync_fall       = !st_reg.sync_sh[2] && st_reg.sync_st;
    end

    // Straps caught in the first cycle after reset release, then held
    if (!st_reg.straps_taken) begin
      st_next.straps       = strap_pins;
      st_next.straps_taken = 1'b1;
    end

    // Register writes; reserved read-write bits are simply stored
    if (wr_fire) begin
      unique case (widx)
        IDX_FAST_RX:  st_next.fast_rx  = (st_reg.fast_rx & ~FAST_RX_RW_MSK) | (wd & FAST_RX_RW_MSK);
        IDX_SYNC:     st_next.sync_rw  = wd & SYNC_RW_MSK;
        IDX_ERRCNT: begin
          do_freeze = wd[FREEZE_BIT] | wd[FREEZE_CLR_BIT];
          do_clear  = wd[FREEZE_CLR_BIT];
        end
        IDX_CHK_CTRL: st_next.chk_ctrl = wd[1:0];
        IDX_IRQ_MASK: st_next.irq_mask = wd[NIRQ-1:0];
        IDX_IRQ_STAT, IDX_SFD_VAR, IDX_STRAPS, IDX_TOTAL: wr_ok = 1'b1; // Read-only; write ignored
        default:      wr_ok = 1'b0;
      endcase
      st_next.bresp = wr_ok ? 2'b00 : 2'b10;
    end

    // Pattern checker counters; mode 0 saturates, mode 1 wraps
    if (st_reg.chk_ctrl[CHK_EN_BIT] && checker_in.byte_valid) begin
      if (st_reg.total_live == TOTAL_MAX) begin
        st_next.total_ovf = 1'b1;
        if (st_reg.chk_ctrl[CHK_MODE_BIT]) begin
          st_next.total_live = 16'h0000;
        end
        else if (!st_reg.total_ovf) begin
          ev[IRQ_TOTAL_SAT] = 1'b1;
        end
      end
      else begin
        st_next.total_live = st_reg.total_live + 16'h0001;
      end
      if (checker_in.byte_error && (st_reg.err_live != ERR_MAX || st_reg.chk_ctrl[CHK_MODE_BIT])) begin
        st_next.err_live = st_reg.err_live + 8'h01;
      end
    end
    if (st_reg.total_live == TOTAL_MAX && !st_reg.chk_ctrl[CHK_MODE_BIT]) begin
      st_next.total_live = TOTAL_MAX;
    end
    if (!st_reg.frozen) begin
      st_next.total_view = st_next.total_live;
      st_next.err_view   = st_next.err_live;
    end
    if (do_freeze) begin
      st_next.frozen     = 1'b1;
      st_next.total_view = st_reg.total_live;
      st_next.err_view   = st_reg.err_live;
    end
    if (do_clear) begin
      st_next.total_live = 16'h0000;
      st_next.err_live   = 8'h00;
      st_next.total_ovf  = 1'b0;
    end

    // Read path: one register word per index, 16 bits in the low half
    if (s_axi_arvalid && st_reg.arready) begin
      rd_fire = 1'b1;
      unique case (ridx)
        IDX_FAST_RX:  rd = st_reg.fast_rx;
        IDX_SYNC:     rd = st_reg.sync_rw | (16'(st_reg.sync_st) << SYNC_BIT);
        IDX_SFD_VAR:  rd = {8'h00, master_delimiter_variation, slave_delimiter_variation};
        IDX_STRAPS:   rd = {2'b00, st_reg.straps, 1'b0};
        IDX_TOTAL:    rd = st_reg.total_view;
        IDX_ERRCNT:   rd = (16'(st_reg.total_ovf) << ERR_OVF_BIT) | {8'h00, st_reg.err_view};
        IDX_CHK_CTRL: rd = {14'h0000, st_reg.chk_ctrl};
        IDX_IRQ_STAT: rd = 16'(st_reg.irq_stat);
        IDX_IRQ_MASK: rd = 16'(st_reg.irq_mask);
        default:      rd_ok = 1'b0;
      endcase
      st_next.rdata   = {16'h0000, rd};
      st_next.rresp   = rd_ok ? 2'b00 : 2'b10;
      st_next.rvalid  = 1'b1;
      st_next.arready = 1'b0;
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid  = 1'b0;
      st_next.arready = 1'b1;
    end

    // Sticky events; a read of the status clears, a new event in that cycle wins
    ev[IRQ_SYNC_UP] = sync_rise;
    ev[IRQ_SYNC_DN] = sync_fall;
    if (rd_fire && ridx == IDX_IRQ_STAT) begin
      st_next.irq_stat = '0;
    end
    st_next.irq_stat = st_next.irq_stat | ev;

    // Block outputs, registered
    st_next.erv    = st_next.fast_rx[0];
    st_next.macsel = (st_next.straps.opmode == PMSR_RGMII_SGMII ||
                      st_next.straps.opmode == PMSR_SGMII_COPPER) ? st_next.straps.mirror : 1'b0;
    st_next.irq    = |(st_next.irq_stat & st_next.irq_mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Synchronous reset to constants only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg         <= '0;
      st_reg.awready <= 1'b1;
      st_reg.wready  <= 1'b1;
      st_reg.arready <= 1'b1;
      st_reg.fast_rx <= RST_FAST_RX;
    end
    else begin
      st_reg <= st_next;
    end
  end

  // Ports come straight from state flip-flops
  assign s_axi_awready          = st_reg.awready;
  assign s_axi_wready           = st_reg.wready;
  assign s_axi_bresp            = st_reg.bresp;
  assign s_axi_bvalid           = st_reg.bvalid;
  assign s_axi_arready          = st_reg.arready;
  assign s_axi_rdata            = st_reg.rdata;
  assign s_axi_rresp            = st_reg.rresp;
  assign s_axi_rvalid           = st_reg.rvalid;
  assign early_receive_valid_en = st_reg.erv;
  assign mac_if_select          = st_reg.macsel;
  assign irq                    = st_reg.irq;

endmodule : pmsr_regs

`default_nettype wire

// ---- pmsr_regs_monitor.sv ----
// Purpose: Concurrent checks on the register bank ports
// Assumes: One clock, synchronous active-low reset
// Notes:   The read bound allows one cycle of slack; the write bound equals its two-cycle figure
`timescale 1ns/1ns
`default_nettype none
module pmsr_regs_monitor (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire pmsr_pkg::pmsr_strap_s strap_pins,
  input wire logic                  early_receive_valid_en,
  input wire logic                  mac_if_select,
  input wire logic                  irq
);
  import pmsr_pkg::*;
  // ----------------------------------------------------------------
  // Handshake and output checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Answers come within a bounded time and stand until taken
  a_write_answered: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  a_read_answered: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data missing");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  // Only one transfer of each kind outstanding
  a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while answering");
  a_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
    else $error("bad write response code");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  // Interface select only in the two bridge modes, following the mirror strap
  a_mac_bridge: assert property (mac_if_select |-> strap_pins.mirror &&
    (strap_pins.opmode == PMSR_RGMII_SGMII || strap_pins.opmode == PMSR_SGMII_COPPER))
    else $error("interface select outside bridge mode");
  a_early_by_write: assert property (!$stable(early_receive_valid_en) |-> !s_axi_awready)
    else $error("early valid changed without write");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_irq: cover property ($rose(irq));
  c_mac: cover property (mac_if_select);
endmodule : pmsr_regs_monitor
bind pmsr_regs pmsr_regs_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .strap_pins(strap_pins), .early_receive_valid_en(early_receive_valid_en),
  .mac_if_select(mac_if_select), .irq(irq));
`default_nettype wire

// ---- phy_misc_status_regs_tb.sv ----
// Purpose: Self-checking bench for the register bank
// Assumes: Bus tasks never overlap; straps change only inside reset
// Notes:   Freeze is sticky, so saturation runs after a fresh reset
`timescale 1ns/1ns
`default_nettype none
module phy_misc_status_regs_tb;
  import pmsr_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, sync_pin, early, mac, irq;
  logic [9:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, mvar, svar;
  logic [1:0]  bresp, rresp;
  logic [7:0]  v;
  pmsr_strap_s straps;
  pmsr_chk_s   chk;
  int          errors, checks_done, seed, n;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  pmsr_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .strap_pins(straps),
    .serial_sync_pin(sync_pin), .master_delimiter_variation(mvar), .slave_delimiter_variation(svar),
    .checker_in(chk), .early_receive_valid_en(early), .mac_if_select(mac), .irq(irq));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [33:0] e, input logic [33:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp
  task automatic results();
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  // A used-up wait is a mismatch and ends the run
  task automatic tmo();
    if (n >= 50) begin
      errors++;
      results();
    end
  endtask : tmo
  // Results are noted in queues and compared when they appear
  always @(posedge aclk) begin
    if (rvalid && rready) cmp(rq.pop_front(), {rresp, rdata});
    if (bvalid && bready) cmp({32'h0, bq.pop_front()}, {32'h0, bresp});
  end
  // Ready is raised only after the answer, so the slave must hold it
  task automatic wr(input logic [7:0] idx, input logic [15:0] d, input logic [1:0] e);
    bq.push_back(e);
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    for (n = 0; n < 50 && (awvalid || wvalid || !bvalid); n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    tmo();
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [1:0] e, input logic [15:0] d);
    rq.push_back({e, 16'h0000, d});
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    for (n = 0; n < 50 && (arvalid || !rvalid); n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    tmo();
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd
  task automatic rst(input int c);
    aresetn <= 1'b0;
    repeat (c) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask : rst
  task automatic stream(input int k, input logic e);
    @(posedge aclk);
    chk.byte_valid <= 1'b1;
    repeat (k) begin
      @(posedge aclk);
      chk.byte_error <= e & 1'($random(seed));
    end
    chk.byte_valid <= 1'b0;
    chk.byte_error <= 1'b0;
  endtask : stream
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, sync_pin} = '0;
    {awaddr, araddr, wdata, mvar, svar, chk, straps} = '0;
    wstrb = 4'h3;
    seed = 91898;
    errors = 0;
    checks_done = 0;
    rst(12);
    rd(IDX_FAST_RX, 2'h0, RST_FAST_RX);
    rd(IDX_SYNC, 2'h0, 16'h0000);
    // Every operating mode code, mirror set in mode 3 only of the bridges
    for (int m = 0; m < 8; m++) begin
      v = 8'($random(seed));
      straps <= {v[7], m[0], m[2:0], v};
      rst(2);
      rd(IDX_STRAPS, 2'h0, {2'b00, straps, 1'b0});
      cmp(34'(m[0] && (m == 3 || m == 6)), 34'(mac));
    end
    wr(IDX_FAST_RX, 16'hFFFF, 2'h0);
    rd(IDX_FAST_RX, 2'h0, 16'h0FFF);
    cmp(34'h1, 34'(early));
    wr(IDX_FAST_RX, 16'hF5A2, 2'h0);
    rd(IDX_FAST_RX, 2'h0, 16'h05A2);
    cmp(34'h0, 34'(early));
    wr(IDX_STRAPS, 16'hFFFF, 2'h0);
    rd(IDX_STRAPS, 2'h0, {2'b00, straps, 1'b0});
    wr(8'h00, 16'h1234, 2'h2);
    rd(8'h00, 2'h2, 16'h0000);
    // Sync rise raises the interrupt; a masked fall does not
    wr(IDX_IRQ_MASK, 16'h0007, 2'h0);
    wr(IDX_SYNC, 16'hFFFF, 2'h0);
    rd(IDX_SYNC, 2'h0, 16'hF800);
    sync_pin <= 1'b1;
    repeat (6) @(posedge aclk);
    rd(IDX_SYNC, 2'h0, 16'hF900);
    cmp(34'h1, 34'(irq));
    rd(IDX_IRQ_STAT, 2'h0, 16'h0001);
    repeat (3) @(posedge aclk);
    cmp(34'h0, 34'(irq));
    wr(IDX_IRQ_MASK, 16'h0000, 2'h0);
    sync_pin <= 1'b0;
    repeat (6) @(posedge aclk);
    cmp(34'h0, 34'(irq));
    rd(IDX_IRQ_STAT, 2'h0, 16'h0002);
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      {mvar, svar} <= v;
      rd(IDX_SFD_VAR, 2'h0, {8'h00, v});
    end
    // Count, then freeze the visible total while bytes keep coming
    wr(IDX_CHK_CTRL, 16'h0001, 2'h0);
    stream(37, 1'b0);
    rd(IDX_TOTAL, 2'h0, 16'd37);
    wr(IDX_ERRCNT, 16'h0001, 2'h0);
    stream(5, 1'b1);
    rd(IDX_TOTAL, 2'h0, 16'd37);
    // Fresh reset clears the sticky freeze before the saturation run
    rst(2);
    wr(IDX_CHK_CTRL, 16'h0001, 2'h0);
    wr(IDX_IRQ_MASK, 16'h0004, 2'h0);
    stream(65540, 1'b0);
    rd(IDX_TOTAL, 2'h0, TOTAL_MAX);
    cmp(34'h1, 34'(irq));
    rd(IDX_IRQ_STAT, 2'h0, 16'h0004);
    wr(IDX_ERRCNT, 16'h0002, 2'h0);
    rd(IDX_ERRCNT, 2'h0, 16'h0000);
    rd(IDX_TOTAL, 2'h0, TOTAL_MAX);
    results();
  end
endmodule : phy_misc_status_regs_tb
`default_nettype wire
